// ---- wdr_pkg.sv ----
`default_nettype none

package wdr_pkg;

  // CPU clock and the half clock unit used for reset pulse timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TCL_NS        = CLK_PERIOD_NS / 2;

  // Reset pulse thresholds, in half clock units as printed.
  localparam int DETECT_MIN_TCL = 4;
  localparam int SHORT_MAX_TCL  = 1038;
  localparam int INT_SEQ_TCL    = 1024;

  // Least times round up to whole cycles, longest times round down.
  function automatic int tcl_cyc_up(input int half_clock_unit);
    int c;
    c = (half_clock_unit * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int tcl_cyc_dn(input int half_clock_unit);
    int c;
    c = (half_clock_unit * TCL_NS) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int LOW_CNT_W = 11;
  localparam logic [LOW_CNT_W-1:0] DETECT_MIN_CYC = LOW_CNT_W'(tcl_cyc_up(DETECT_MIN_TCL));
  localparam logic [LOW_CNT_W-1:0] SHORT_MAX_CYC  = LOW_CNT_W'(tcl_cyc_dn(SHORT_MAX_TCL));
  localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX    = 11'h7ff;
  localparam logic [9:0]           SEQ_CYC        = 10'(tcl_cyc_up(INT_SEQ_TCL));
  // Release of the pull to a settled synchronised pin level.
  localparam logic [2:0]           SETTLE_CYC     = 3'h5;

  // Watchdog prescaler and counter.
  localparam int         DIV_FAST      = 2;
  localparam int         DIV_SLOW      = 128;
  localparam logic [6:0] PSC_FAST_LAST = 7'(DIV_FAST - 1);
  localparam logic [6:0] PSC_SLOW_LAST = 7'(DIV_SLOW - 1);
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [7:0]  RELOAD_RST   = 8'h00;
  localparam logic        PSEL_RST     = 1'h0;

  // Register map: the control register index times four is its byte address.
  localparam logic [31:0] CTRL_INDEX = 32'h0000_ffae;
  localparam logic [31:0] CTRL_ADDR  = CTRL_INDEX * 32'h0000_0004;
  localparam logic [31:0] STAT_ADDR  = 32'h0003_fec0;
  localparam logic [31:0] MASK_ADDR  = 32'h0003_fec4;
  localparam logic [31:0] CNT_ADDR   = 32'h0003_fec8;

  // Control register fields.
  localparam int RELOAD_LSB = 8;
  localparam int PON_BIT    = 5;
  localparam int LONG_BIT   = 4;
  localparam int SHORT_BIT  = 3;
  localparam int SW_BIT     = 2;
  localparam int OVF_BIT    = 1;
  localparam int PSEL_BIT   = 0;

  // Flag patterns per reset source, laid out as control bits 5..0.
  localparam logic [5:0] PAT_PON   = 6'h3c;
  localparam logic [5:0] PAT_LONG  = 6'h1c;
  localparam logic [5:0] PAT_SHORT = 6'h0c;
  localparam logic [5:0] PAT_SW    = 6'h04;
  localparam logic [5:0] PAT_WDT   = 6'h06;
  localparam logic [5:0] OVF_MASK  = 6'h02;

  // Interrupt status and mask layout.
  localparam int IRQ_W     = 4;
  localparam int IRQ_WDT   = 0;
  localparam int IRQ_SW    = 1;
  localparam int IRQ_SHORT = 2;
  localparam int IRQ_LONG  = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  typedef enum logic [2:0] {
    S_IDLE, S_PIN_LOW, S_SEQ, S_SETTLE, S_EXTEND
  } wdr_state_t;

  typedef enum logic [1:0] {
    SRC_PIN, SRC_SW, SRC_WDT
  } wdr_src_t;

endpackage

`default_nettype wire

// ---- wdr_top.sv ----
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Watchdog runs after every reset; disable only accepted before end of init.
// - Counter overflow starts internal reset and drives reset output pin low.
// - Counter ticks at clock over 2 when prescale select is 0, else 128.
// - 16-bit counter; service loads high byte from reload value field.
// - Overflow time is 512 clocks times (1 + select*63) times (256 - reload).
// - Overflow flag set on overflow, cleared by pin reset or service.
// - Software reset instruction sets the software flag.
// - End of init clears all flags; before it several flags may coexist.
// - Bus writes never alter any reset indication flag.
// - Each reset source sets its own documented set of flags.
// - Control layout: reload 15:8, flags 5:1, prescale select bit 0.
// - Pin still low after internal sequence turns the reset into a long one.
// - Pin low longer than 1038 half clocks is a long pin reset.
// - Pin low over 4 and up to 1038 half clocks is a short reset.
// - Pin low enters reset at once: outputs low, holds cancelled, bus aborted, pins idle.
// - Reset mode pin sampled while pin low; low selects asynchronous handling.
module wdr_top
  import wdr_pkg::*;
(
  // Clock and power-on reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // CPU instruction strobes.
  input  wire logic        service_instr_i,
  input  wire logic        software_reset_instr_i,
  input  wire logic        end_of_init_instr_i,
  input  wire logic        disable_instr_i,
  input  wire logic        bidir_reset_en_i,
  // Reset pins.
  input  wire logic        reset_input_pin_n_i,
  output logic             reset_input_pin_o,
  output logic             reset_input_pin_oe_o,
  input  wire logic        reset_mode_pin_i,
  output logic             reset_output_pin_n_o,
  // System reset controls.
  output logic             internal_reset_o,
  output logic             async_reset_mode_o,
  output logic             hold_cancel_o,
  output logic             bus_abort_o,
  output logic             io_hiz_o,
  output logic             configuration_port_pullup_o,
  output logic             irq_o
);

  wdr_state_t           state_r, state_nxt;
  wdr_src_t             src_r;
  logic [2:0]           pin_sync_r, mode_sync_r;
  logic                 pin_lvl_r, mode_lvl_r;
  logic [LOW_CNT_W-1:0] low_cnt_r;
  logic [9:0]           seq_cnt_r;
  logic [2:0]           settle_cnt_r;
  logic                 finish;
  logic                 cls_long, cls_short, cls_sw, cls_wdt;
  logic                 rst_act_r, entry_r, pull_oe_r, async_mode_r;
  logic [5:0]           flags_r, flags_nxt;
  logic [7:0]           reload_r;
  logic                 psel_r, wdt_en_r, end_of_init_instr_r;
  logic [6:0]           psc_r;
  logic [15:0]          cnt_r;
  logic                 instr_ok, run, tick, ovf;
  logic                 wr_pend_r, rd_pend_r;
  logic [31:0]          addr_r, hrdata_r, rdata_c;
  logic                 wr_ctrl, wr_stat, wr_mask;
  logic [IRQ_W-1:0]     stat_r, mask_r, irq_evt;

  // Pin synchronisers: a level counts once the second and third stages agree.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_sync_r  <= 3'h7;
      mode_sync_r <= 3'h7;
      pin_lvl_r   <= 1'h1;
      mode_lvl_r  <= 1'h1;
    end else begin
      pin_sync_r  <= {pin_sync_r[1:0], reset_input_pin_n_i};
      mode_sync_r <= {mode_sync_r[1:0], reset_mode_pin_i};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_lvl_r <= pin_sync_r[2];
      end
      if (mode_sync_r[1] == mode_sync_r[2]) begin
        mode_lvl_r <= mode_sync_r[2];
      end
    end
  end

  // Reset sequencer; pin reset wins over a same-cycle overflow or software reset.
  always_comb begin
    state_nxt = state_r;
    finish    = 1'h0;
    unique case (state_r)
      S_IDLE: begin
        if (!pin_lvl_r) begin
          state_nxt = S_PIN_LOW;
        end else if (ovf || (instr_ok && software_reset_instr_i)) begin
          state_nxt = S_SEQ;
        end
      end
      S_PIN_LOW: begin
        if (pin_lvl_r) begin
          if (low_cnt_r <= DETECT_MIN_CYC) begin
            state_nxt = S_IDLE;
          end else if (low_cnt_r > SHORT_MAX_CYC) begin
            state_nxt = S_IDLE;
            finish    = 1'h1;
          end else begin
            state_nxt = S_SEQ;
          end
        end
      end
      S_SEQ: begin
        if (seq_cnt_r >= SEQ_CYC) begin
          state_nxt = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (settle_cnt_r == SETTLE_CYC) begin
          if (!pin_lvl_r) begin
            state_nxt = S_EXTEND;
          end else begin
            state_nxt = S_IDLE;
            finish    = 1'h1;
          end
        end
      end
      S_EXTEND: begin
        if (pin_lvl_r) begin
          state_nxt = S_IDLE;
          finish    = 1'h1;
        end
      end
    endcase
  end

  // Classification at the end of a reset; an extended one always reads as long.
  assign cls_long  = finish && (state_r == S_PIN_LOW || state_r == S_EXTEND);
  assign cls_short = finish && state_r == S_SETTLE && src_r == SRC_PIN;
  assign cls_sw    = finish && state_r == S_SETTLE && src_r == SRC_SW;
  assign cls_wdt   = finish && state_r == S_SETTLE && src_r == SRC_WDT;

  // State and source registers.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= S_IDLE;
      src_r   <= SRC_PIN;
    end else begin
      state_r <= state_nxt;
      if (state_r == S_IDLE && state_nxt != S_IDLE) begin
        src_r <= !pin_lvl_r ? SRC_PIN : (ovf ? SRC_WDT : SRC_SW);
      end
    end
  end

  // Sequence timers: pulse length, internal sequence and pin settling.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt_r    <= '0;
      seq_cnt_r    <= '0;
      settle_cnt_r <= '0;
    end else begin
      if (state_r == S_IDLE) begin
        low_cnt_r <= {{(LOW_CNT_W-1){1'h0}}, !pin_lvl_r};
      end else if (state_r == S_PIN_LOW && !pin_lvl_r && low_cnt_r != LOW_CNT_MAX) begin
        low_cnt_r <= low_cnt_r + 1'h1;
      end
      if (state_r == S_IDLE) begin
        seq_cnt_r <= '0;
      end else if (seq_cnt_r != SEQ_CYC) begin
        seq_cnt_r <= seq_cnt_r + 1'h1;
      end
      if (state_r == S_SETTLE) begin
        settle_cnt_r <= settle_cnt_r + 1'h1;
      end else begin
        settle_cnt_r <= '0;
      end
    end
  end

  // Pin-facing controls, registered so they never glitch.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_act_r    <= 1'h1;
      entry_r      <= 1'h0;
      pull_oe_r    <= 1'h0;
      async_mode_r <= 1'h1;
    end else begin
      rst_act_r <= (state_nxt != S_IDLE);
      entry_r   <= (state_r == S_IDLE && state_nxt != S_IDLE);
      pull_oe_r <= bidir_reset_en_i && (state_nxt == S_SEQ);
      // The mode pin is followed for as long as the reset pin reads low, whoever pulls it.
      if (state_r != S_IDLE && !pin_lvl_r) begin
        async_mode_r <= !mode_lvl_r;
      end
    end
  end

  assign reset_output_pin_n_o        = !rst_act_r;
  assign internal_reset_o            = rst_act_r;
  assign io_hiz_o                    = rst_act_r;
  assign configuration_port_pullup_o = rst_act_r;
  assign hold_cancel_o               = entry_r;
  assign bus_abort_o                 = entry_r;
  assign reset_input_pin_o           = 1'h0;
  assign reset_input_pin_oe_o        = pull_oe_r;
  assign async_reset_mode_o          = async_mode_r;

  // Instructions only act while the CPU runs, that is outside a reset.
  assign instr_ok = (state_r == S_IDLE);

  // Flags: clears are applied first, so a same-cycle set always wins.
  always_comb begin
    flags_nxt = flags_r;
    if (instr_ok && service_instr_i) begin
      flags_nxt[OVF_BIT] = 1'h0;
    end
    if (instr_ok && end_of_init_instr_i) begin
      flags_nxt = '0;
    end
    if (cls_long) begin
      flags_nxt = (flags_nxt & ~OVF_MASK) | PAT_LONG;
    end
    if (cls_short) begin
      flags_nxt = (flags_nxt & ~OVF_MASK) | PAT_SHORT;
    end
    if (cls_sw) begin
      flags_nxt = flags_nxt | PAT_SW;
    end
    if (cls_wdt) begin
      flags_nxt = flags_nxt | PAT_WDT;
    end
  end

  // The flags have no bus write path at all; only events above change them.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r <= PAT_PON;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Watchdog enable; an internal reset re-arms it and reopens the disable window.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdt_en_r <= 1'h1;
      end_of_init_instr_r  <= 1'h0;
    end else if (finish) begin
      wdt_en_r <= 1'h1;
      end_of_init_instr_r  <= 1'h0;
    end else if (instr_ok) begin
      if (end_of_init_instr_i) begin
        end_of_init_instr_r <= 1'h1;
      end
      if (disable_instr_i && !end_of_init_instr_r) begin
        wdt_en_r <= 1'h0;
      end
    end
  end

  // Control fields; an internal reset restores their reset values.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reload_r <= RELOAD_RST;
      psel_r   <= PSEL_RST;
    end else if (finish) begin
      reload_r <= RELOAD_RST;
      psel_r   <= PSEL_RST;
    end else if (wr_ctrl) begin
      reload_r <= hwdata_i[RELOAD_LSB +: 8];
      psel_r   <= hwdata_i[PSEL_BIT];
    end
  end

  // Prescaler tick and overflow; the counter halts while a reset runs.
  assign run  = instr_ok && wdt_en_r;
  assign tick = run && (psc_r == (psel_r ? PSC_SLOW_LAST : PSC_FAST_LAST));
  assign ovf  = tick && (cnt_r == CNT_MAX);

  // Counter counts up from reload:00, giving (256 - reload) * 256 ticks.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      psc_r <= '0;
      cnt_r <= CNT_RST;
    end else if (finish) begin
      psc_r <= '0;
      cnt_r <= CNT_RST;
    end else if (instr_ok && service_instr_i) begin
      psc_r <= '0;
      cnt_r <= {reload_r, 8'h00};
    end else if (run) begin
      psc_r <= tick ? 7'h00 : psc_r + 1'h1;
      if (tick) begin
        cnt_r <= cnt_r + 1'h1;
      end
    end
  end

  // Bus address phase capture; a read takes one wait state to fetch data.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_r <= 1'h0;
      rd_pend_r <= 1'h0;
      addr_r    <= '0;
    end else if (hready_i) begin
      wr_pend_r <= hsel_i && htrans_i[1] && hwrite_i;
      rd_pend_r <= hsel_i && htrans_i[1] && !hwrite_i;
      addr_r    <= haddr_i;
    end else begin
      rd_pend_r <= 1'h0;
    end
  end

  assign wr_ctrl = wr_pend_r && (addr_r == CTRL_ADDR);
  assign wr_stat = wr_pend_r && (addr_r == STAT_ADDR);
  assign wr_mask = wr_pend_r && (addr_r == MASK_ADDR);

  // Read decode; unmapped addresses read as zero.
  always_comb begin
    rdata_c = '0;
    if (addr_r == CTRL_ADDR) begin
      rdata_c[15:0] = {reload_r, 2'h0, flags_r[5:1], psel_r};
    end else if (addr_r == STAT_ADDR) begin
      rdata_c[IRQ_W-1:0] = stat_r;
    end else if (addr_r == MASK_ADDR) begin
      rdata_c[IRQ_W-1:0] = mask_r;
    end else if (addr_r == CNT_ADDR) begin
      rdata_c[15:0] = cnt_r;
    end
  end

  // Read data register, loaded during the wait state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_r <= '0;
    end else if (rd_pend_r) begin
      hrdata_r <= rdata_c;
    end
  end

  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = !rd_pend_r;
  assign hresp_o     = 1'h0;

  // Interrupt events, one per completed reset class.
  always_comb begin
    irq_evt            = '0;
    irq_evt[IRQ_WDT]   = cls_wdt;
    irq_evt[IRQ_SW]    = cls_sw;
    irq_evt[IRQ_SHORT] = cls_short;
    irq_evt[IRQ_LONG]  = cls_long;
  end

  // Sticky status cleared by writing ones; a new event beats the clear.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat_r <= IRQ_RST;
      mask_r <= IRQ_RST;
    end else begin
      stat_r <= (stat_r & ~(wr_stat ? hwdata_i[IRQ_W-1:0] : IRQ_RST)) | irq_evt;
      if (wr_mask) begin
        mask_r <= hwdata_i[IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(stat_r & mask_r);

endmodule

`default_nettype wire

// ---- wdr_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// CPU core model: turns a bench request into one instruction strobe.
module wdr_cpu_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Requests from the bench.
  input  wire logic       go_i,
  input  wire logic [1:0] op_i,
  input  wire logic       in_reset_i,
  // Instruction strobes.
  output logic            service_o,
  output logic            swrst_o,
  output logic            end_of_init_instr_o,
  output logic            disable_o
);
  logic [3:0] strobe_r;

  // A core held in reset executes nothing, so a request then is dropped.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strobe_r <= 4'h0;
    end else begin
      strobe_r <= (go_i && !in_reset_i) ? (4'h1 << op_i) : 4'h0;
    end
  end

  // Opcodes 0 to 3 are service, software reset, end of init and disable.
  assign service_o = strobe_r[0];
  assign swrst_o   = strobe_r[1];
  assign end_of_init_instr_o   = strobe_r[2];
  assign disable_o = strobe_r[3];
endmodule

`default_nettype wire

// ---- wdr_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

// Pin level checks on reset entry, sequencing and bus timing.
module wdr_top_asserts (
  // Clock and reset.
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // Register bus.
  input wire logic       hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hwrite_i,
  input wire logic       hready_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  // Reset pins and controls.
  input wire logic       software_reset_instr_i,
  input wire logic       bidir_reset_en_i,
  input wire logic       reset_input_pin_n_i,
  input wire logic       reset_input_pin_o,
  input wire logic       reset_input_pin_oe_o,
  input wire logic       reset_output_pin_n_o,
  input wire logic       internal_reset_o,
  input wire logic       async_reset_mode_o,
  input wire logic       hold_cancel_o,
  input wire logic       bus_abort_o,
  input wire logic       io_hiz_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic [15:0] run_cnt_r;
  logic        armed_r;
  logic        take_w;

  assign take_w = hsel_i & hready_i & htrans_i[1];

  // Length of each reset run; armed only after idle is seen, so the
  // short tail of the power-on reset is not judged.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_cnt_r <= 16'h0000;
      armed_r   <= 1'b0;
    end else begin
      run_cnt_r <= internal_reset_o ? run_cnt_r + 16'h0001 : 16'h0000;
      armed_r   <= armed_r | !internal_reset_o;
    end
  end

  a_resp_okay: assert property (!hresp_o)
    else $error("bus response not okay");
  a_read_wait: assert property (
    take_w && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read did not take exactly one wait state");
  a_write_nowait: assert property (take_w && hwrite_i |=> hreadyout_o)
    else $error("write was stalled");
  a_pin_enters_reset: assert property (
    !reset_input_pin_n_i [*6] |-> ##[0:2] !reset_output_pin_n_o)
    else $error("reset output high while reset pin held low");
  a_entry_cancels: assert property (
    $rose(internal_reset_o) |-> $past(hold_cancel_o && bus_abort_o)
      or ##[0:1] (hold_cancel_o && bus_abort_o))
    else $error("no hold cancel and bus abort at reset entry");
  a_hiz_with_reset: assert property (io_hiz_o == internal_reset_o)
    else $error("pin drivers not idle in step with reset");
  a_swrst_starts: assert property (
    software_reset_instr_i && !internal_reset_o |-> ##[1:3] !reset_output_pin_n_o)
    else $error("software reset did not start a reset");
  a_seq_length: assert property (
    $fell(internal_reset_o) && armed_r |-> run_cnt_r >= 16'h01f4)
    else $error("reset sequence ended too early");
  a_pull_needs_bidir: assert property (
    reset_input_pin_oe_o |-> internal_reset_o && bidir_reset_en_i && !reset_input_pin_o)
    else $error("reset pin pulled outside a bidirectional reset");
  a_async_mode: assert property (
    $changed(async_reset_mode_o) |-> $past(internal_reset_o) or ##[0:2] internal_reset_o)
    else $error("reset mode changed outside reset");
endmodule

bind wdr_top wdr_top_asserts u_chk (
  .clk_i, .reset_n_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o,
  .software_reset_instr_i, .bidir_reset_en_i, .reset_input_pin_n_i, .reset_input_pin_o,
  .reset_input_pin_oe_o, .reset_output_pin_n_o, .internal_reset_o, .async_reset_mode_o,
  .hold_cancel_o, .bus_abort_o, .io_hiz_o
);

`default_nettype wire

// ---- tb_watchdog_reset_source_logic.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_watchdog_reset_source_logic;
  import wdr_pkg::*;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, hrdata_o, r;
  logic [1:0]  htrans_i = 2'h0, op_code = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic        hready_i, hreadyout_o, hresp_o, irq_o, go = 1'b0, ext_n = 1'b1;
  logic        service_instr_i, software_reset_instr_i, end_of_init_instr_i;
  logic        disable_instr_i, bidir_reset_en_i = 1'b0, reset_mode_pin_i = 1'b1;
  logic        reset_input_pin_n_i, reset_input_pin_o, reset_input_pin_oe_o;
  logic        reset_output_pin_n_o, internal_reset_o, async_reset_mode_o;
  logic        hold_cancel_o, bus_abort_o, io_hiz_o, configuration_port_pullup_o;
  logic [15:0] cfg [3] = '{16'hff00, 16'hfe00, 16'hff01};
  int          per [3] = '{512, 1024, 32768};
  int          n, failures = 0, n_checks = 0;

  // Free running 50 MHz clock.
  always #10 clk_i = ~clk_i;

  // One slave, so its ready is the bus ready; the pin wire is low while
  // either the outside world or the device pulls it.
  assign hready_i = hreadyout_o;
  assign reset_input_pin_n_i = ext_n & ~reset_input_pin_oe_o;

  wdr_top DUT (
    .clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .service_instr_i,
    .software_reset_instr_i, .end_of_init_instr_i, .disable_instr_i, .bidir_reset_en_i,
    .reset_input_pin_n_i, .reset_input_pin_o, .reset_input_pin_oe_o, .reset_mode_pin_i,
    .reset_output_pin_n_o, .internal_reset_o, .async_reset_mode_o, .hold_cancel_o,
    .bus_abort_o, .io_hiz_o, .configuration_port_pullup_o, .irq_o
  );

  wdr_cpu_model u_cpu (
    .clk_i, .reset_n_i, .go_i(go), .op_i(op_code), .in_reset_i(internal_reset_o),
    .service_o(service_instr_i), .swrst_o(software_reset_instr_i),
    .end_of_init_instr_o(end_of_init_instr_i), .disable_o(disable_instr_i)
  );

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bchk(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Waits one edge, then keeps waiting while the slave stalls.
  task automatic wait_rdy();
    int i;
    i = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      i++;
      if (i > 16) begin
        bchk(hreadyout_o, 1'b1);
        conclude();
      end
      @(posedge clk_i);
    end
  endtask

  // Single word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    wait_rdy();
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    hwdata_i <= d;
    wait_rdy();
    rd = hrdata_o;
  endtask

  // The extra edge lets a written value reach the outputs.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r);
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  task automatic op(input logic [1:0] o);
    op_code <= o;
    go      <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Counts edges in n until the reset output shows lvl.
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (reset_output_pin_n_o !== lvl) begin
      @(posedge clk_i);
      n++;
      if (n > lim) begin
        bchk(reset_output_pin_n_o, lvl);
        conclude();
      end
    end
  endtask

  task automatic ovf(input logic [15:0] c, input int p);
    wr(CTRL_ADDR, {16'h0000, c});
    op(2'h0);
    wait_rst(1'b0, p + 20);
    bchk(n >= p - 2 && n <= p + 4, 1'b1);
    wait_rst(1'b1, 800);
  endtask

  task automatic pin_pulse(input int len);
    ext_n <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk({internal_reset_o, configuration_port_pullup_o, reset_output_pin_n_o}, 3'h6);
    repeat (len - 20) @(posedge clk_i);
    ext_n <= 1'b1;
    wait_rst(1'b1, 800);
  endtask

  // Main sequence; each reset source is checked through the flags it leaves.
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rdchk(CTRL_ADDR, 32'h0000_003c);
    wr(CTRL_ADDR, 32'h0000_ff3e);
    rdchk(CTRL_ADDR, 32'h0000_ff3c);
    rdchk(32'h0000_0100, 32'h0000_0000);
    op(2'h3);
    op(2'h0);
    repeat (700) @(posedge clk_i);
    bchk(reset_output_pin_n_o, 1'b1);
    op(2'h2);
    rdchk(CTRL_ADDR, 32'h0000_ff00);
    op(2'h1);
    wait_rst(1'b0, 20);
    wait_rst(1'b1, 800);
    rdchk(CTRL_ADDR, 32'h0000_0004);
    for (int k = 0; k < 3; k++) begin
      op(2'h2);
      op(2'h3);
      ovf(cfg[k], per[k]);
      rdchk(CTRL_ADDR, 32'h0000_0006);
      if (k < 2) begin
        op(2'h0);
        rdchk(CTRL_ADDR, 32'h0000_0004);
      end
    end
    rdchk(STAT_ADDR, 32'h0000_0003);
    bchk(irq_o, 1'b0);
    wr(MASK_ADDR, 32'h0000_0001);
    bchk(irq_o, 1'b1);
    rdchk(MASK_ADDR, 32'h0000_0001);
    wr(STAT_ADDR, 32'h0000_0001);
    bchk(irq_o, 1'b0);
    rdchk(STAT_ADDR, 32'h0000_0002);
    pin_pulse(100);
    rdchk(CTRL_ADDR, 32'h0000_000c);
    bchk(async_reset_mode_o, 1'b0);
    reset_mode_pin_i <= 1'b0;
    pin_pulse(600);
    rdchk(CTRL_ADDR, 32'h0000_001c);
    bchk(async_reset_mode_o, 1'b1);
    reset_mode_pin_i <= 1'b1;
    bidir_reset_en_i <= 1'b1;
    op(2'h2);
    op(2'h1);
    repeat (100) @(posedge clk_i);
    bchk(reset_input_pin_oe_o, 1'b1);
    pin_pulse(700);
    rdchk(CTRL_ADDR, 32'h0000_001c);
    bchk(async_reset_mode_o, 1'b0);
    bidir_reset_en_i <= 1'b0;
    wr(CTRL_ADDR, 32'h0000_8000);
    op(2'h0);
    bus(1'b0, CNT_ADDR, 32'h0000_0000, r);
    chk({24'h00_0000, r[15:8]}, 32'h0000_0080);
    bchk(r[7:0] < 8'h10, 1'b1);
    conclude();
  end
endmodule

`default_nettype wire
